// ===== hdl/rx_dma_ctrl.sv
// receive continuation, error/halt control and receive address monitors
// also holds the per-frame status/fetch sequence and the receive request flag
// assumes engine-side strobes share i_clk; only the nmi pin is asynchronous
// assumes software keeps reserved bits at zero and changes control while stopped
`timescale 1ns/10ps
module rx_dma_ctrl
  import rx_dma_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_frame_done,
  input  wire logic              i_buf_write_valid,
  input  wire logic [31:0]       i_buf_write_addr,
  input  wire logic              i_desc_fetch_valid,
  input  wire logic [31:0]       i_desc_fetch_addr,
  input  wire logic              i_desc_addr_illegal,
  input  wire logic              i_tx_fifo_underflow,
  input  wire logic              i_rx_fifo_overflow,
  input  wire logic              i_nmi,
  output logic                   o_receive_request,
  output logic                   o_status_write,
  output logic                   o_next_desc_fetch,
  output logic                   o_halted
);

  // register state
  logic         receive_continuation_reg;
  logic         fifo_error_halt_select_reg;
  logic         address_error_flag_reg;
  logic         halted_flag_reg;
  logic         fifo_halt_reg;
  logic         receive_request_flag_reg;
  logic [31:0]  rx_buffer_write_address_reg;
  logic [31:0]  rx_descriptor_fetch_address_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // nmi synchroniser and filtered level
  logic         nmi_s1_reg;
  logic         nmi_s2_reg;
  logic         nmi_s3_reg;
  logic         nmi_level_reg;
  logic         nmi_rise;

  // frame completion sequence
  frame_state_t state_reg;
  frame_state_t state_next;
  logic         status_write_reg;
  logic         next_fetch_reg;
  logic         rr_clear;

  // decoded write strobes, combined fifo error and engine halt
  logic         wr_rcv_ctrl;
  logic         wr_op_ctrl;
  logic         wr_rcv_req;
  logic         fifo_error;
  logic         engine_halted;

  // flag-clear decodes, halt output, frame accept and readable register images
  logic              halted_out_reg;
  logic              restart_wr;
  logic              address_error_clear_wr;
  logic              frame_accept;
  logic [DATA_W-1:0] receive_control_image;
  logic [DATA_W-1:0] dma_operation_control_image;
  logic [DATA_W-1:0] receive_request_image;

  // byte address decode; upper address bits must be zero to hit
  assign wr_rcv_ctrl = i_wr && (i_addr == ADDR_W'(RECEIVE_CONTROL_OFS));
  assign wr_op_ctrl  = i_wr && (i_addr == ADDR_W'(DMA_OPERATION_CONTROL_OFS));
  assign wr_rcv_req  = i_wr && (i_addr == ADDR_W'(RECEIVE_REQUEST_OFS));

  // flag clears need a written 0; a written 1 leaves the flag alone
  assign restart_wr             = wr_op_ctrl && !i_wdata[HALTED_FLAG_BIT];
  assign address_error_clear_wr = wr_op_ctrl && !i_wdata[ADDRESS_ERROR_FLAG_BIT];

  // halt taken from the output flop, so the port and the sequence agree
  assign engine_halted = halted_out_reg;
  assign fifo_error    = i_tx_fifo_underflow | i_rx_fifo_overflow;

  // receive control register; only the continuation bit is stored
  // no interlock: a change mid-frame only steers the next status cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      receive_continuation_reg <= RECEIVE_CONTROL_RST[RECEIVE_CONTINUATION_BIT];
    end else if (wr_rcv_ctrl) begin
      // written any time; changing it mid-frame is software's hazard
      receive_continuation_reg <= i_wdata[RECEIVE_CONTINUATION_BIT];
    end
  end

  // fifo error select
  // takes effect from the next fifo error, never retroactively
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_error_halt_select_reg <= DMA_OPERATION_CONTROL_RST[FIFO_ERROR_HALT_SELECT_BIT];
    end else if (wr_op_ctrl) begin
      fifo_error_halt_select_reg <= i_wdata[FIFO_ERROR_HALT_SELECT_BIT];
    end
  end

  // address error flag: set wins over a clearing write in the same cycle
  // so an error that lands during the clear is never lost
  // the flag only reports; it does not stop frame handling
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      address_error_flag_reg <= DMA_OPERATION_CONTROL_RST[ADDRESS_ERROR_FLAG_BIT];
    end else if (i_desc_addr_illegal) begin
      address_error_flag_reg <= 1'b1;
    end else if (address_error_clear_wr) begin
      address_error_flag_reg <= 1'b0; // write 1 is a no-op
    end
  end

  // nmi pin: three flops, level taken only when second and third agree
  // the first flop may go metastable, so nothing else reads it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_s1_reg    <= 1'b0;
      nmi_s2_reg    <= 1'b0;
      nmi_s3_reg    <= 1'b0;
      nmi_level_reg <= 1'b0;
    end else begin
      nmi_s1_reg <= i_nmi;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
      if (nmi_s2_reg == nmi_s3_reg) begin
        nmi_level_reg <= nmi_s3_reg;
      end
    end
  end

  // edge, so a held nmi does not block the restart write forever
  assign nmi_rise = (nmi_s2_reg == nmi_s3_reg) && nmi_s3_reg && !nmi_level_reg;

  // halted flag: nmi edge sets, write 0 restarts, set wins
  // a restart holds while the pin stays high, since only an edge sets it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halted_flag_reg <= DMA_OPERATION_CONTROL_RST[HALTED_FLAG_BIT];
    end else if (nmi_rise) begin
      halted_flag_reg <= 1'b1;
    end else if (restart_wr) begin
      halted_flag_reg <= 1'b0;
    end
  end

  // fifo error halt; released by the same restart write as the halted flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_halt_reg <= 1'b0;
    end else if (fifo_error && fifo_error_halt_select_reg) begin
      fifo_halt_reg <= 1'b1;
    end else if (restart_wr) begin
      fifo_halt_reg <= 1'b0;
    end
  end

  // combined halt flop; either cause shows one cycle after it is set
  // one flop keeps the halt output glitch-free at the port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halted_out_reg <= 1'b0;
    end else begin
      halted_out_reg <= halted_flag_reg | fifo_halt_reg;
    end
  end

  // receive request flag: software sets by writing 1, engine clears
  // software may raise it again at any time to resume reception
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      receive_request_flag_reg <= RECEIVE_REQUEST_RST[RECEIVE_REQUEST_FLAG_BIT];
    end else if (wr_rcv_req && i_wdata[RECEIVE_REQUEST_FLAG_BIT]) begin
      receive_request_flag_reg <= 1'b1; // a fresh request beats the engine clear
    end else if (rr_clear) begin
      receive_request_flag_reg <= 1'b0;
    end
  end

  // a frame end counts only while requested, running and idle
  // frame ends closer together than the sequence are dropped
  assign frame_accept = i_frame_done && receive_request_flag_reg && !engine_halted && (state_reg == ST_WAIT);

  // frame completion next state
  always_comb begin
    state_next = state_reg;
    rr_clear   = 1'b0;
    case (state_reg)
      ST_WAIT: begin
        if (frame_accept) begin
          state_next = ST_STATUS;
        end
      end
      ST_STATUS: begin
        // status goes out in this state whatever the continuation setting
        if (receive_continuation_reg) begin
          state_next = ST_FETCH;
        end else begin
          state_next = ST_WAIT;
          rr_clear   = 1'b1;
        end
      end
      ST_FETCH: begin
        // one fetch pulse per completed frame in continuous mode
        state_next = ST_WAIT;
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  // state register
  // returns to wait after every frame, so a stuck state cannot persist
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // one-cycle command pulses to the engine datapath
  // taken from state_next so each pulse lines up with its state
  // and leaves the port straight from a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_write_reg <= 1'b0;
      next_fetch_reg   <= 1'b0;
    end else begin
      status_write_reg <= (state_next == ST_STATUS);
      next_fetch_reg   <= (state_next == ST_FETCH);
    end
  end

  // monitors follow engine strobes only, so bus writes cannot touch them
  // a read may trail the engine by the one-cycle capture delay
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_buffer_write_address_reg <= MONITOR_RST;
    end else if (i_buf_write_valid) begin
      rx_buffer_write_address_reg <= i_buf_write_addr; // one cycle behind
    end
  end

  // descriptor fetch monitor
  // holds the start address of the last fetch until the next one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_descriptor_fetch_address_reg <= MONITOR_RST;
    end else if (i_desc_fetch_valid) begin
      rx_descriptor_fetch_address_reg <= i_desc_fetch_addr;
    end
  end

  // receive control image; reserved bits come from the zero reset word
  always_comb begin
    receive_control_image                           = DATA_W'(RECEIVE_CONTROL_RST);
    receive_control_image[RECEIVE_CONTINUATION_BIT] = receive_continuation_reg;
  end

  // operation control image; bit 0 and bits above the select stay zero
  // the fifo halt is not part of it, only the nmi halt reads back
  always_comb begin
    dma_operation_control_image                             = DATA_W'(DMA_OPERATION_CONTROL_RST);
    dma_operation_control_image[FIFO_ERROR_HALT_SELECT_BIT] = fifo_error_halt_select_reg;
    dma_operation_control_image[ADDRESS_ERROR_FLAG_BIT]     = address_error_flag_reg;
    dma_operation_control_image[HALTED_FLAG_BIT]            = halted_flag_reg;
  end

  // receive request image
  always_comb begin
    receive_request_image                           = DATA_W'(RECEIVE_REQUEST_RST);
    receive_request_image[RECEIVE_REQUEST_FLAG_BIT] = receive_request_flag_reg;
  end

  // read mux; reserved and unmapped bits read zero
  // whole-word images keep each address to one assignment
  always_comb begin
    rdata_next = DATA_W'(UNMAPPED_READ_VALUE);
    // unmapped offsets fall to the default and read zero
    case (i_addr)
      ADDR_W'(RECEIVE_CONTROL_OFS): begin
        rdata_next = receive_control_image;
      end
      ADDR_W'(DMA_OPERATION_CONTROL_OFS): begin
        rdata_next = dma_operation_control_image;
      end
      ADDR_W'(RX_BUFFER_WRITE_ADDR_MON_OFS): begin
        rdata_next = DATA_W'(rx_buffer_write_address_reg);
      end
      ADDR_W'(RX_DESC_FETCH_ADDR_MON_OFS): begin
        rdata_next = DATA_W'(rx_descriptor_fetch_address_reg);
      end
      ADDR_W'(RECEIVE_REQUEST_OFS): begin
        rdata_next = receive_request_image;
      end
      default: begin
        rdata_next = DATA_W'(UNMAPPED_READ_VALUE);
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  // zero otherwise, so stale data never looks like an answer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // outputs straight from flops
  // the halt output lags the readable flag by one cycle
  assign o_rdata           = rdata_reg;
  assign o_receive_request = receive_request_flag_reg;
  assign o_status_write    = status_write_reg;
  assign o_next_desc_fetch = next_fetch_reg;
  assign o_halted          = halted_out_reg;

endmodule

// ===== hdl/rx_dma_ctrl_pkg.sv
// package for the receive control and monitor slice of the ethernet dma engine
// assumes a 32-bit register port with byte addresses and one system clock
package rx_dma_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] RECEIVE_CONTROL_OFS          = 8'h00;
  localparam logic [7:0] DMA_OPERATION_CONTROL_OFS    = 8'h04;
  localparam logic [7:0] RX_BUFFER_WRITE_ADDR_MON_OFS = 8'h08;
  localparam logic [7:0] RX_DESC_FETCH_ADDR_MON_OFS   = 8'h0c;
  localparam logic [7:0] RECEIVE_REQUEST_OFS          = 8'h10;

  // field positions
  localparam int RECEIVE_CONTINUATION_BIT   = 0;
  localparam int FIFO_ERROR_HALT_SELECT_BIT = 3;
  localparam int ADDRESS_ERROR_FLAG_BIT     = 2;
  localparam int HALTED_FLAG_BIT            = 1;
  localparam int RECEIVE_REQUEST_FLAG_BIT   = 0;

  // reset values
  localparam logic [31:0] RECEIVE_CONTROL_RST       = 32'h0000_0000;
  localparam logic [31:0] DMA_OPERATION_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] MONITOR_RST               = 32'h0000_0000;
  localparam logic [31:0] RECEIVE_REQUEST_RST       = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ_VALUE       = 32'h0000_0000;

  // per-frame completion sequence
  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_STATUS = 2'b01,
    ST_FETCH  = 2'b10
  } frame_state_t;

endpackage

// ===== test/rx_dma_ctrl_checker.sv
// assertions on the frame outputs and register port of rx_dma_ctrl
// assumes one clock domain and sight of the top ports only
`timescale 1ns/10ps
module rx_dma_ctrl_checker
  import rx_dma_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              i_frame_done,
  input wire logic              i_tx_fifo_underflow,
  input wire logic              i_rx_fifo_overflow,
  input wire logic              i_nmi,
  input wire logic              o_receive_request,
  input wire logic              o_status_write,
  input wire logic              o_next_desc_fetch,
  input wire logic              o_halted
);
  logic cont_reg;
  logic fec_reg;
  // shadows of the control bits, since the checker cannot see the registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cont_reg <= 1'b0;
      fec_reg  <= 1'b0;
    end else if (i_wr && i_addr == RECEIVE_CONTROL_OFS) begin
      cont_reg <= i_wdata[RECEIVE_CONTINUATION_BIT];
    end else if (i_wr && i_addr == DMA_OPERATION_CONTROL_OFS) begin
      fec_reg <= i_wdata[FIFO_ERROR_HALT_SELECT_BIT];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // a frame end is taken only while requested, running and idle
  sequence s_taken; i_frame_done && o_receive_request && !o_halted && !o_status_write && !o_next_desc_fetch; endsequence
  sequence s_status_cont; o_status_write && cont_reg; endsequence
  property p_status; s_taken |=> o_status_write; endproperty
  a_status: assert property (p_status) else $error("status write missing");
  property p_status_cause; o_status_write |-> $past(i_frame_done) ##1 !o_status_write; endproperty
  a_status_cause: assert property (p_status_cause) else $error("stray status write");
  property p_cont_fetch; s_status_cont |=> o_next_desc_fetch ##1 !o_next_desc_fetch; endproperty
  a_cont_fetch: assert property (p_cont_fetch) else $error("next fetch missing");
  property p_stop; o_status_write && !cont_reg && !i_wr |=> !o_receive_request; endproperty
  a_stop: assert property (p_stop) else $error("request not cleared");
  property p_fetch_cause; o_next_desc_fetch |-> $past(o_status_write) && cont_reg; endproperty
  a_fetch_cause: assert property (p_fetch_cause) else $error("stray fetch");
  property p_rdata_idle; !i_rd |=> o_rdata == '0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_rsvd_ops; i_rd && i_addr == DMA_OPERATION_CONTROL_OFS |=> o_rdata[31:4] == '0 && !o_rdata[0]; endproperty
  a_rsvd_ops: assert property (p_rsvd_ops) else $error("reserved bits set");
  property p_rsvd_rc; i_rd && i_addr == RECEIVE_CONTROL_OFS |=> o_rdata[31:1] == '0; endproperty
  a_rsvd_rc: assert property (p_rsvd_rc) else $error("reserved bits set");
  property p_fifo_halt; fec_reg && (i_rx_fifo_overflow || i_tx_fifo_underflow) |-> ##[1:2] o_halted; endproperty
  a_fifo_halt: assert property (p_fifo_halt) else $error("no halt on fifo error");
  property p_nmi_halt; $rose(i_nmi) |-> ##[2:6] o_halted; endproperty
  a_nmi_halt: assert property (p_nmi_halt) else $error("no halt on nmi");
endmodule

// ===== test/rx_engine_model.sv
// far-side receive engine model: buffer writes, frame ends, descriptor fetches
// assumes the bench starts a frame only while reception is requested
`timescale 1ns/10ps
module rx_engine_model #(
  parameter logic [31:0] DESC_BASE = 32'h0000_1000
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic [31:0] i_buf_addr,
  input  wire logic        i_next_desc_fetch,
  output logic             o_frame_done,
  output logic             o_buf_write_valid,
  output logic [31:0]      o_buf_write_addr,
  output logic             o_desc_fetch_valid,
  output logic [31:0]      o_desc_fetch_addr
);
  logic [31:0] desc_ptr_reg;
  // buffer write, then frame end; idle address toggles so stale values never pass
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_frame_done      <= 1'b0;
      o_buf_write_valid <= 1'b0;
      o_buf_write_addr  <= 32'h0;
    end else begin
      o_buf_write_valid <= i_go;
      o_frame_done      <= o_buf_write_valid;
      o_buf_write_addr  <= i_go ? i_buf_addr : ~o_buf_write_addr;
    end
  end
  // descriptors sit 16 bytes apart, a stride of this model's own choosing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      desc_ptr_reg       <= DESC_BASE;
      o_desc_fetch_valid <= 1'b0;
      o_desc_fetch_addr  <= 32'h0;
    end else begin
      o_desc_fetch_valid <= i_next_desc_fetch;
      desc_ptr_reg       <= i_next_desc_fetch ? desc_ptr_reg + 32'h10 : desc_ptr_reg;
      o_desc_fetch_addr  <= i_next_desc_fetch ? desc_ptr_reg + 32'h10 : ~o_desc_fetch_addr;
    end
  end
endmodule

// ===== test/rx_dma_ctrl_test.sv
// self-checking bench for rx_dma_ctrl with the engine model and checker
// assumes a 20 MHz clock and the register map of rx_dma_ctrl_pkg
`timescale 1ns/10ps
module rx_dma_ctrl_test;
  import rx_dma_ctrl_pkg::*;
  localparam logic [31:0] DESC_BASE = 32'h0000_1000;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_nmi = 1'b0, go = 1'b0;
  logic        i_desc_addr_illegal = 1'b0, i_tx_fifo_underflow = 1'b0, i_rx_fifo_overflow = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, go_addr = 32'h0, rnd_state = 32'h0001_564c;
  logic        i_frame_done, i_buf_write_valid, i_desc_fetch_valid, rd_pend = 1'b0;
  logic        o_receive_request, o_status_write, o_next_desc_fetch, o_halted;
  logic [31:0] i_buf_write_addr, i_desc_fetch_addr, o_rdata;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  always #25 i_clk = ~i_clk;
  rx_dma_ctrl u_rx_dma_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frame_done(i_frame_done),
    .i_buf_write_valid(i_buf_write_valid), .i_buf_write_addr(i_buf_write_addr),
    .i_desc_fetch_valid(i_desc_fetch_valid), .i_desc_fetch_addr(i_desc_fetch_addr),
    .i_desc_addr_illegal(i_desc_addr_illegal), .i_tx_fifo_underflow(i_tx_fifo_underflow),
    .i_rx_fifo_overflow(i_rx_fifo_overflow), .i_nmi(i_nmi), .o_receive_request(o_receive_request),
    .o_status_write(o_status_write), .o_next_desc_fetch(o_next_desc_fetch), .o_halted(o_halted));
  rx_engine_model #(.DESC_BASE(DESC_BASE)) u_rx_engine_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go),
    .i_buf_addr(go_addr), .i_next_desc_fetch(o_next_desc_fetch), .o_frame_done(i_frame_done),
    .o_buf_write_valid(i_buf_write_valid), .o_buf_write_addr(i_buf_write_addr),
    .o_desc_fetch_valid(i_desc_fetch_valid), .o_desc_fetch_addr(i_desc_fetch_addr));
  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // strobes drop for one cycle after each access so no signal is set twice at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic frame(input logic [31:0] a);
    go <= 1'b1;
    go_addr <= a;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
  // read data stands only the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_pend) begin
      chk(o_rdata, exp_q.pop_front());
    end
    rd_pend <= i_rd;
  end
  // bound well above the roughly 120 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    test_done();
  end
  initial begin
    logic [31:0] a;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int k = 0; k < 6; k++) rd(8'(k * 4), 32'h0);
    // single frame with continuation off stops reception
    wr(RECEIVE_REQUEST_OFS, 32'h1);
    frame(rnd());
    rd(RECEIVE_REQUEST_OFS, 32'h0);
    // reception stopped, so control may change now
    wr(RECEIVE_CONTROL_OFS, 32'h0000_0001);
    rd(RECEIVE_CONTROL_OFS, 32'h1);
    wr(DMA_OPERATION_CONTROL_OFS, 32'h0000_000e);
    rd(DMA_OPERATION_CONTROL_OFS, 32'h8);
    wr(DMA_OPERATION_CONTROL_OFS, 32'h0);
    // two back-to-back frames in continuous mode
    wr(RECEIVE_REQUEST_OFS, 32'h1);
    frame(rnd());
    a = rnd();
    frame(a);
    rd(RECEIVE_REQUEST_OFS, 32'h1);
    rd(RX_DESC_FETCH_ADDR_MON_OFS, DESC_BASE + 32'h20);
    for (int k = 0; k < 4; k++) wr(k[0] ? RX_DESC_FETCH_ADDR_MON_OFS : RX_BUFFER_WRITE_ADDR_MON_OFS, rnd());
    rd(RX_BUFFER_WRITE_ADDR_MON_OFS, a);
    rd(RX_DESC_FETCH_ADDR_MON_OFS, DESC_BASE + 32'h20);
    // illegal descriptor address; a write of one must not clear it
    i_desc_addr_illegal <= 1'b1;
    @(posedge i_clk);
    i_desc_addr_illegal <= 1'b0;
    @(posedge i_clk);
    wr(DMA_OPERATION_CONTROL_OFS, 32'h4);
    rd(DMA_OPERATION_CONTROL_OFS, 32'h4);
    wr(DMA_OPERATION_CONTROL_OFS, 32'h0);
    rd(DMA_OPERATION_CONTROL_OFS, 32'h0);
    // nmi halt, then restart while the pin is still held
    i_nmi <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd(DMA_OPERATION_CONTROL_OFS, 32'h2);
    wr(DMA_OPERATION_CONTROL_OFS, 32'h0);
    @(negedge i_clk);
    chk({31'h0, o_halted}, 32'h0);
    @(posedge i_clk);
    i_nmi <= 1'b0;
    // fifo error halts only when selected
    for (int k = 1; k >= 0; k--) begin
      wr(DMA_OPERATION_CONTROL_OFS, 32'(k * 8));
      i_rx_fifo_overflow <= k[0];
      i_tx_fifo_underflow <= !k[0];
      @(posedge i_clk);
      i_rx_fifo_overflow <= 1'b0;
      i_tx_fifo_underflow <= 1'b0;
      repeat (2) @(negedge i_clk);
      chk({31'h0, o_halted}, 32'(k));
      @(posedge i_clk);
      wr(DMA_OPERATION_CONTROL_OFS, 32'h0);
    end
    test_done();
  end
endmodule
bind rx_dma_ctrl rx_dma_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_rx_dma_ctrl_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_frame_done(i_frame_done), .i_tx_fifo_underflow(i_tx_fifo_underflow),
  .i_rx_fifo_overflow(i_rx_fifo_overflow), .i_nmi(i_nmi), .o_receive_request(o_receive_request),
  .o_status_write(o_status_write), .o_next_desc_fetch(o_next_desc_fetch), .o_halted(o_halted));
